// file: logic/sac_top.v
// Conversion control for a 10-bit successive-approximation converter with APB registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sac_consts.vh"

module sac_top #(
	parameter DATA_W = 10
) (
	input  wire                clk_sys_i,
	input  wire                srst_i,
	input  wire                psel_i,
	input  wire                penable_i,
	input  wire                pwrite_i,
	input  wire [31:0]         paddr_i,
	input  wire [31:0]         pwdata_i,
	output wire [31:0]         prdata_o,
	output wire                pready_o,
	output wire                pslverr_o,
	output wire [2:0]          channel_select_o,
	output wire                conv_sample_o,
	output wire                conv_step_o,
	input  wire                comparator_i,
	input  wire                touch_press_n_i,
	output wire [15:0]         reference_and_pin_control_o,
	output wire [3:0]          shared_analog_pin_o,
	output wire [3:0]          shared_analog_pin_oe_o,
	output wire                conv_dma_req_o,
	output wire                conv_irq_o,
	output wire                touch_press_request_o
);

	// Sequencer states
	localparam ST_IDLE = 2'd0;
	localparam ST_ARM  = 2'd1;
	localparam ST_CONV = 2'd2;
	localparam ST_DONE = 2'd3;

	reg  [15:0]       ctrl_q;
	reg  [15:0]       clkdiv_q;
	reg  [15:0]       refpin_q;
	reg  [15:0]       pinout_q;
	reg  [14:0]       div_cnt_q;
	reg               tick_q;
	reg  [1:0]        state_q;
	reg  [1:0]        state_d;
	reg  [1:0]        arm_cnt_q;
	reg  [5:0]        bit_cnt_q;
	reg  [DATA_W-1:0] sar_q;
	reg               busy_q;
	reg  [2:0]        res_ch_q;
	reg  [DATA_W-1:0] res_val_q;
	reg               done_q;
	reg               rearm_q;
	reg  [31:0]       prdata_q;
	reg               touch_q;

	wire [15:0] word_idx;
	wire        addr_ok;
	wire        sel_ctrl;
	wire        sel_clkdiv;
	wire        sel_refpin;
	wire        sel_pinout;
	wire        wr_en;
	wire        rd_en;
	wire        start_bit;
	wire        single_mode;
	wire [2:0]  ch_sel;
	wire        ch_valid;
	wire [15:0] result_word;
	wire        hide_status;

	// Apply a write mask so reserved bits always stay zero
	function [15:0] wmask;
		input [15:0] old_v;
		input [15:0] new_v;
		input [15:0] mask;
		begin
			wmask = (old_v & ~mask) | (new_v & mask);
		end
	endfunction

	// APB decode; registers sit on word addresses, byte address is index times four
	assign word_idx   = paddr_i[17:2];
	assign addr_ok    = (paddr_i[31:`SAC_ADDR_W] == 14'h0000) && (paddr_i[1:0] == 2'b00);
	assign sel_ctrl   = addr_ok && (word_idx == `SAC_IDX_CTRL);
	assign sel_clkdiv = addr_ok && (word_idx == `SAC_IDX_CLKDIV);
	assign sel_refpin = addr_ok && (word_idx == `SAC_IDX_REFPIN);
	assign sel_pinout = addr_ok && (word_idx == `SAC_IDX_PINOUT);
	assign wr_en      = psel_i && penable_i && pwrite_i;
	assign rd_en      = psel_i && !penable_i && !pwrite_i;
	assign pready_o   = 1'b1;
	// Unmapped addresses and writes to the read-only result answer with an error
	assign pslverr_o  = psel_i && penable_i &&
	                    !(sel_ctrl || sel_clkdiv || sel_refpin || sel_pinout ||
	                      (!pwrite_i && addr_ok && word_idx == `SAC_IDX_RESULT));
	assign prdata_o   = prdata_q;

	assign start_bit   = ctrl_q[`SAC_CTRL_START];
	assign single_mode = ctrl_q[`SAC_CTRL_SINGLE];
	assign ch_sel      = ctrl_q[`SAC_CTRL_CH_HI:`SAC_CTRL_CH_LO];
	assign ch_valid    = (ch_sel < `SAC_CHANNELS);
	assign hide_status = refpin_q[`SAC_REF_HIDE];

	// Result word: status bits forced to zero when hidden for DMA capture
	assign result_word = hide_status ? {6'h00, res_val_q} :
	                     {busy_q, res_ch_q, 2'b00, res_val_q};

	// Registers; only srst_i (hardware reset) touches them, no halt input exists
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctrl_q   <= `SAC_CTRL_RST;
			clkdiv_q <= `SAC_CLKDIV_RST;
			refpin_q <= `SAC_REF_RST;
			pinout_q <= `SAC_PIN_RST;
		end else begin
			if (wr_en && sel_ctrl) begin
				ctrl_q <= wmask(ctrl_q, pwdata_i[15:0], `SAC_CTRL_WMASK);
			end else if (done_q && (single_mode || !start_bit)) begin
				// Single shot ends the sequence by dropping the start bit
				ctrl_q[`SAC_CTRL_START] <= 1'b0;
			end
			if (wr_en && sel_clkdiv) begin
				clkdiv_q <= wmask(clkdiv_q, pwdata_i[15:0], `SAC_CLKDIV_WMASK);
			end
			if (wr_en && sel_refpin) begin
				refpin_q <= wmask(refpin_q, pwdata_i[15:0], `SAC_REF_WMASK);
			end
			if (wr_en && sel_pinout) begin
				pinout_q <= wmask(pinout_q, pwdata_i[15:0], `SAC_PIN_WMASK);
			end
		end
	end

	// Read data captured in the setup phase so it stands through the access
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			prdata_q <= 32'h00000000;
		end else if (rd_en) begin
			if (sel_ctrl) begin
				prdata_q <= {16'h0000, ctrl_q};
			end else if (addr_ok && word_idx == `SAC_IDX_RESULT) begin
				prdata_q <= {16'h0000, result_word};
			end else if (sel_clkdiv) begin
				prdata_q <= {16'h0000, clkdiv_q};
			end else if (sel_refpin) begin
				prdata_q <= {16'h0000, refpin_q};
			end else if (sel_pinout) begin
				prdata_q <= {16'h0000, pinout_q};
			end else begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// Conversion clock tick once every divisor+1 system clocks
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			div_cnt_q <= 15'h0000;
			tick_q    <= 1'b0;
		end else if (div_cnt_q >= clkdiv_q[14:0]) begin
			div_cnt_q <= 15'h0000;
			tick_q    <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 15'h0001;
			tick_q    <= 1'b0;
		end
	end

	// Next state of the sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_bit && !rearm_q && ch_valid) begin
					state_d = ST_ARM;
				end
			end
			ST_ARM: begin
				if (tick_q && arm_cnt_q == `SAC_START_DELAY - 2'd1) begin
					state_d = ST_CONV;
				end
			end
			ST_CONV: begin
				if (tick_q && bit_cnt_q == `SAC_CONV_CYCLES - 6'd1) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				// Continuous mode goes straight into the next sample
				state_d = (start_bit && !single_mode) ? ST_CONV : ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer datapath: 32 ticks per sample, first 21 sample, then 10 bit trials and one last tick
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_q    <= ST_IDLE;
			arm_cnt_q  <= 2'd0;
			bit_cnt_q  <= 6'd0;
			sar_q      <= {DATA_W{1'b0}};
			busy_q     <= 1'b0;
			res_ch_q   <= 3'h7;
			res_val_q  <= {DATA_W{1'b0}};
			done_q     <= 1'b0;
			rearm_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= 1'b0;
			// Single shot must see the start bit cleared before another run
			if (!start_bit) begin
				rearm_q <= 1'b0;
			end else if (state_q == ST_DONE && single_mode) begin
				rearm_q <= 1'b1;
			end
			if (state_q == ST_IDLE) begin
				arm_cnt_q <= 2'd0;
			end else if (state_q == ST_ARM && tick_q) begin
				arm_cnt_q <= arm_cnt_q + 2'd1;
			end
			if (state_d == ST_CONV && state_q != ST_CONV) begin
				busy_q    <= 1'b1;
				bit_cnt_q <= 6'd0;
				sar_q     <= {1'b1, {(DATA_W-1){1'b0}}};
			end else if (state_q == ST_CONV && tick_q) begin
				bit_cnt_q <= bit_cnt_q + 6'd1;
				// Bit trials run on ticks 21..30 after a long sample phase
				if (bit_cnt_q >= 6'd21 && bit_cnt_q <= 6'd30) begin
					if (!comparator_i) begin
						sar_q <= sar_q & ~({{(DATA_W-1){1'b0}}, 1'b1} << (6'd30 - bit_cnt_q));
					end
					if (bit_cnt_q != 6'd30) begin
						sar_q <= (comparator_i ? sar_q :
						          sar_q & ~({{(DATA_W-1){1'b0}}, 1'b1} << (6'd30 - bit_cnt_q))) |
						         ({{(DATA_W-1){1'b0}}, 1'b1} << (6'd29 - bit_cnt_q));
					end
				end
			end
			if (state_q == ST_CONV && state_d == ST_DONE) begin
				res_val_q  <= sar_q;
				res_ch_q   <= ch_sel;
				busy_q     <= 1'b0;
				done_q     <= 1'b1;
			end
		end
	end

	// Completion pulse feeds both DMA and the processor interrupt
	assign conv_dma_req_o = done_q;
	assign conv_irq_o     = done_q;

	// Pen press: touch line low, independent of the sequencer
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			touch_q <= 1'b0;
		end else begin
			touch_q <= !touch_press_n_i;
		end
	end
	assign touch_press_request_o = touch_q;

	// Analog front-end hooks
	assign channel_select_o            = ch_sel;
	assign conv_sample_o               = (state_q == ST_CONV) && (bit_cnt_q < 6'd21);
	assign conv_step_o                 = (state_q == ST_CONV) && tick_q;
	assign reference_and_pin_control_o = refpin_q;

	// Pin drivers: pin zero can only sink, so it is enabled only when its value is low
	assign shared_analog_pin_o[3:1]    = pinout_q[3:1];
	assign shared_analog_pin_o[0]      = 1'b0;
	assign shared_analog_pin_oe_o[3:1] = pinout_q[`SAC_PIN_EN_LO+3:`SAC_PIN_EN_LO+1];
	assign shared_analog_pin_oe_o[0]   = pinout_q[`SAC_PIN_EN_LO] && !pinout_q[0];

endmodule // sac_top

// file: logic/sac_consts.vh
// Constants for the successive-approximation converter control block
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// Register word indices; byte address is four times the index
`define SAC_IDX_CTRL       16'h7012
`define SAC_IDX_RESULT     16'h7014
`define SAC_IDX_CLKDIV     16'h7016
`define SAC_IDX_REFPIN     16'h7018
`define SAC_IDX_PINOUT     16'h701a
`define SAC_ADDR_W         18

// Control register fields
`define SAC_CTRL_START     15
`define SAC_CTRL_CH_HI     14
`define SAC_CTRL_CH_LO     12
`define SAC_CTRL_MULTI     11
`define SAC_CTRL_SINGLE    10
`define SAC_CTRL_RST       16'h0000
`define SAC_CTRL_WMASK     16'hfc00

// Result register fields
`define SAC_RES_BUSY       15
`define SAC_RES_RST        16'h7000

// Clock divider register
`define SAC_CLKDIV_RST     16'h7fff
`define SAC_CLKDIV_WMASK   16'h7fff

// Reference and pin control register
`define SAC_REF_HIDE       14
`define SAC_REF_RST        16'h0000
`define SAC_REF_WMASK      16'h7777

// Pin output control: enables in [7:4], values in [3:0]
`define SAC_PIN_EN_LO      4
`define SAC_PIN_RST        16'h0000
`define SAC_PIN_WMASK      16'h00ff

// Conversion sequencing
`define SAC_CONV_CYCLES    6'd32
`define SAC_START_DELAY    2'd3
`define SAC_CHANNELS       3'd6

`endif

// file: tb/sac_top_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
module sac_top_chk (
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic        touch_press_n_i,
	input wire logic [15:0] reference_and_pin_control_o,
	input wire logic [3:0]  shared_analog_pin_o,
	input wire logic        conv_dma_req_o,
	input wire logic        conv_irq_o,
	input wire logic        touch_press_request_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// Access phase of a bus transfer
	wire acc = psel_i && penable_i;
	irq_with_dma_a: assert property (conv_dma_req_o |-> conv_irq_o)
		else $error("completion irq missing");
	// A conversion is far longer than eight clocks, so pulses never crowd
	dma_single_a: assert property (conv_dma_req_o |=> (!conv_dma_req_o)[*8])
		else $error("dma pulse too long");
	touch_follow_a: assert property ($past(!srst_i) |-> touch_press_request_o == !$past(touch_press_n_i))
		else $error("touch request wrong");
	pin0_low_a: assert property (shared_analog_pin_o[0] == 1'b0)
		else $error("pin zero driven high");
	ref_reserved_a: assert property ((reference_and_pin_control_o & 16'h8888) == 16'h0)
		else $error("reserved bit set");
	err_misalign_a: assert property (acc && paddr_i[1:0] != 2'b0 |-> pslverr_o)
		else $error("misaligned not refused");
	err_result_a: assert property (acc && pwrite_i && paddr_i == 32'h1c050 |-> pslverr_o)
		else $error("result write not refused");
	err_phase_a: assert property (pslverr_o |-> acc)
		else $error("error outside access");
	upper_zero_a: assert property (prdata_o[31:16] == 16'h0)
		else $error("upper read half set");
	reset_clear_a: assert property ($fell(srst_i) |-> prdata_o == 32'h0 && !conv_dma_req_o && !touch_press_request_o)
		else $error("outputs not cleared");
	cover property (conv_dma_req_o);
	cover property (acc && pslverr_o);
	cover property (touch_press_request_o);
endmodule // sac_top_chk

bind sac_top sac_top_chk chk_u (.clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
	.pslverr_o, .touch_press_n_i, .reference_and_pin_control_o, .shared_analog_pin_o, .conv_dma_req_o,
	.conv_irq_o, .touch_press_request_o);

// file: tb/sac_analog_model.sv
// Behavioural analog side: comparator and touch panel line
`timescale 1ns/10ps
module sac_analog_model (
	input  wire logic clk_sys_i,
	input  wire logic conv_sample_i,
	input  wire logic conv_step_i,
	input  wire logic level_i,
	input  wire logic press_i,
	output wire logic comparator_o,
	output wire logic touch_press_n_o
);
	logic tog_q = 1'b0;
	// Outside bit trials the comparator means nothing, so it churns
	always @(posedge clk_sys_i) begin
		tog_q <= ~tog_q;
	end
	assign comparator_o = (conv_step_i && !conv_sample_i) ? level_i : tog_q;
	// Pull-up holds the line high until the panel shorts it
	assign touch_press_n_o = press_i ? 1'b0 : 1'b1;
endmodule // sac_analog_model

// file: tb/sar_adc_conversion_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, conv_sample_o, conv_step_o, comparator_i, touch_press_n_i, er;
	logic conv_dma_req_o, conv_irq_o, touch_press_request_o, level = 1'b0, press = 1'b0;
	logic [2:0] channel_select_o;
	logic [3:0] shared_analog_pin_o, shared_analog_pin_oe_o;
	logic [15:0] reference_and_pin_control_o, v, exp_q[$];
	logic [15:0] dflt[5] = '{16'h0000, 16'h7000, 16'h7fff, 16'h0000, 16'h0000};
	int mismatches = 0, cmp_count = 0, n, d, ch;
	realtime t0;
	always #20 clk_sys_i = ~clk_sys_i;
	sac_top dut_u (.clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .channel_select_o, .conv_sample_o, .conv_step_o, .comparator_i,
		.touch_press_n_i, .reference_and_pin_control_o, .shared_analog_pin_o, .shared_analog_pin_oe_o,
		.conv_dma_req_o, .conv_irq_o, .touch_press_request_o);
	sac_analog_model model_u (.clk_sys_i, .conv_sample_i(conv_sample_o), .conv_step_i(conv_step_o),
		.level_i(level), .press_i(press), .comparator_o(comparator_i), .touch_press_n_o(touch_press_n_i));
	task automatic wrap_up();
		$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Setup cycle, then access held until ready is seen at an edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] wd);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {16'h0, wd};
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (pready_o !== 1'b1 && k < 16);
		if (k >= 16) begin
			mismatches++;
			wrap_up();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// Bounded wait for a completion pulse
	task automatic wait_done();
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (conv_dma_req_o !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			mismatches++;
			wrap_up();
		end
		chk(conv_irq_o, 1);
	endtask
	task automatic quiet(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(posedge clk_sys_i);
			#1;
			n += int'(conv_dma_req_o);
		end
		chk(n, 0);
	endtask
	task automatic hw_reset();
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 32'h1c048 + 8 * i, 16'h0);
			chk(rd, {16'h0, dflt[i]});
		end
	endtask
	initial begin
		void'($urandom(32'h6a3192fa));
		hw_reset();
		$display("Done: reset values");
		// Refused places read zero and flag an error
		foreach (dflt[i]) begin
			// Last one reads a mapped word through address bits that must be zero
			apb(i[0], i < 3 ? 32'h1c049 + 35 * i : 32'h1c050 + (i - 3) * 32'h40000000, 16'hffff);
			chk(er, 1);
			chk(rd, 32'h0);
		end
		apb(1'b1, 32'h1c060, 16'h3000);
		for (ch = 0; ch < 6; ch++) begin
			d = $urandom_range(3);
			level <= 1'($urandom_range(1));
			apb(1'b1, 32'h1c058, d[15:0]);
			exp_q.push_back({1'b0, ch[2:0], 2'b00, {10{level}}});
			apb(1'b1, 32'h1c048, {1'b1, ch[2:0], 2'b01, 10'h0});
			t0 = $realtime;
			// Let the write settle before looking at the register outputs
			#1;
			chk(32'(channel_select_o), ch);
			chk(32'(reference_and_pin_control_o), 32'h3000);
			do apb(1'b0, 32'h1c050, 16'h0); while (rd[15] !== 1'b1 && $realtime - t0 < 4000);
			chk(rd[15], 1);
			wait_done();
			n = int'(($realtime - t0) / 40);
			chk(32'(n >= 34 * (d + 1) && n <= 36 * (d + 1) + 2), 1);
			apb(1'b0, 32'h1c050, 16'h0);
			chk(rd, {16'h0, exp_q.pop_front()});
			apb(1'b0, 32'h1c048, 16'h0);
			chk(rd, {16'h0, 1'b0, ch[2:0], 12'h400});
		end
		$display("Done: single conversions");
		apb(1'b1, 32'h1c060, 16'h7000);
		apb(1'b1, 32'h1c048, 16'hd000);
		wait_done();
		repeat (3) begin
			t0 = $realtime;
			apb(1'b0, 32'h1c050, 16'h0);
			chk(rd, {22'h0, {10{level}}});
			wait_done();
			n = int'(($realtime - t0) / 40);
			chk(32'(n >= 32 * (d + 1) && n <= 32 * (d + 1) + 1), 1);
		end
		apb(1'b1, 32'h1c048, 16'h5000);
		wait_done();
		quiet(40 * (d + 1));
		$display("Done: continuous mode");
		apb(1'b1, 32'h1c048, 16'he400);
		quiet(200);
		repeat (4) begin
			v = 16'($urandom_range(255));
			apb(1'b1, 32'h1c068, v);
			#1;
			chk(32'(shared_analog_pin_oe_o), {v[7:5], v[4] & ~v[0]});
			chk(32'(shared_analog_pin_o), {v[3:1], 1'b0});
		end
		// Touch line changes on a clock edge like every other input
		@(posedge clk_sys_i);
		press <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(touch_press_request_o, 1);
		@(posedge clk_sys_i);
		press <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(touch_press_request_o, 0);
		$display("Done: pins and touch");
		apb(1'b1, 32'h1c048, 16'h9000);
		repeat (20) @(posedge clk_sys_i);
		hw_reset();
		$display("Done: reset mid-run");
		wrap_up();
	end
endmodule // sar_adc_conversion_control_tb_top
